// ### logic/lvs_pkg.sv
/*
 package for the serial link serializer/deserializer block:
 register offsets, field layouts, timing counts and state types.
 assumes a 40 MHz system clock; one serial bit lasts SUB_STEPS clocks.
*/
package lvs_pkg;
   // register bus
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_SLIP = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_ROLL = 4'hC;
   // status field positions
   localparam int ST_RX_LOCK = 0;
   localparam int ST_TX_LOCK = 1;
   localparam int ST_CAL_BUSY = 2;
   localparam int ST_DPA_LSB = 8;
   localparam int ST_ROLL_LSB = 16;
   // bit timing: eight sampling phases per bit
   localparam int SUB_STEPS = 8;
   localparam int SUB_W = 3;
   localparam logic [SUB_W-1:0] SUB_LAST = 3'h7;
   localparam logic [SUB_W-1:0] CENTER_OFS = 3'h4;
   localparam logic [SUB_W-1:0] CAL_ADVANCE = 3'h2;
   localparam logic [SUB_W-1:0] NO_ADVANCE = 3'h0;
   localparam int FWD_W = 5;
   localparam int LOCK_EDGES = 4;
   // times
   localparam int CLK_PERIOD_NS = 25;
   localparam int PLL_LOCK_NS = 2000;
   localparam int PLL_LOCK_CYCLES = (PLL_LOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAL_NS = 800;
   localparam int CAL_CYCLES = (CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // forwarded clock divide codes
   localparam logic [1:0] DIV_FULL = 2'h0;
   localparam logic [1:0] DIV_HALF = 2'h1;
   localparam logic [1:0] DIV_QUARTER = 2'h2;
   localparam logic [1:0] DIV_RSVD = 2'h3;

   typedef struct packed {
      logic cal_start;
      logic ext_pll;
      logic soft_cdr;
      logic [2:0] fwd_phase;
      logic [1:0] fwd_div;
   } lvs_ctrl_type;
   localparam int CTRL_W = $bits(lvs_ctrl_type);
   localparam lvs_ctrl_type CTRL_RESET = 8'h00;

   typedef enum logic {
      CAL_IDLE = 1'b0,
      CAL_RUN = 1'b1
   } lvs_cal_state_type;
endpackage

// ### logic/lvs_tx_lane.sv
/*
 one transmit lane: loads a parallel word and shifts it out msb first.
 assumes load and shift strobes come from the top's bit timing.
*/
`timescale 1ns/100ps
module lvs_tx_lane #(
   parameter int SER_FACTOR = 8
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic load_in,
   input wire logic shift_in,
   input wire logic [SER_FACTOR-1:0] word_in,
   output logic serial_out
);
   import lvs_pkg::*;
   logic [SER_FACTOR-1:0] shift_reg;

   // shift register and serial output both cleared by lane reset
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         shift_reg <= '0;
         serial_out <= 1'h0;
      end else if (load_in) begin
         serial_out <= word_in[SER_FACTOR-1];
         shift_reg <= {word_in[SER_FACTOR-2:0], 1'h0};
      end else if (shift_in) begin
         serial_out <= shift_reg[SER_FACTOR-1];
         shift_reg <= {shift_reg[SER_FACTOR-2:0], 1'h0};
      end
   end

   property p_msb_first;
      @(posedge clock_in) disable iff (!rst_n_in)
      load_in |=> serial_out == $past(word_in[SER_FACTOR-1]) && shift_reg == {$past(word_in[SER_FACTOR-2:0]), 1'h0};
   endproperty
   a_msb_first: assert property (p_msb_first) else $error("tx lane did not start with msb");
endmodule

// ### logic/lvs_rx_lane.sv
/*
 one receive lane: pin synchroniser, phase aligner, sample history,
 bit-slip realignment and rollover flag.
 assumes common bit timing from the top; serial_in is asynchronous.
*/
`timescale 1ns/100ps
module lvs_rx_lane #(
   parameter int SER_FACTOR = 8,
   parameter int MAX_SLIP = 8,
   parameter int SLIP_W = 4
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic phase_rst_n_in,
   input wire logic realign_rst_n_in,
   input wire logic serial_in,
   input wire logic hold_in,
   input wire logic align_in,
   input wire logic soft_cdr_in,
   input wire logic word_tick_in,
   input wire logic [lvs_pkg::SUB_W-1:0] sub_cnt_in,
   input wire logic [lvs_pkg::SUB_W-1:0] adv_in,
   input wire logic [SLIP_W-1:0] roll_cnt_in,
   output logic [SER_FACTOR-1:0] word_out,
   output logic locked_out,
   output logic rollover_out,
   output logic rec_clock_out
);
   import lvs_pkg::*;
   localparam int HIST_W = SER_FACTOR + MAX_SLIP;
   localparam int BIT_W = $clog2(SER_FACTOR);
   localparam int WORD_CYC = SER_FACTOR * SUB_STEPS;
   localparam int WORD_M1 = WORD_CYC - 1;
   localparam int TMR_W = $clog2(WORD_CYC);
   localparam int EDGE_W = $clog2(LOCK_EDGES);

   logic s1_reg, s2_reg, s3_reg, line_reg, prev_reg;
   logic [SUB_W-1:0] phase_reg, sample_pt;
   logic [EDGE_W-1:0] edge_cnt_reg;
   logic [HIST_W-1:0] hist_reg;
   logic [BIT_W-1:0] lane_bit_reg;
   logic [SLIP_W-1:0] slip_reg;
   logic [TMR_W-1:0] roll_tmr_reg;
   logic sample, edge_seen;

   // pin synchroniser: level changes once stages two and three agree
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_reg <= 1'h0;
         s2_reg <= 1'h0;
         s3_reg <= 1'h0;
         line_reg <= 1'h0;
         prev_reg <= 1'h0;
      end else begin
         s1_reg <= serial_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         if (s2_reg == s3_reg) begin
            line_reg <= s3_reg;
         end
         prev_reg <= line_reg;
      end
   end

   assign edge_seen = line_reg != prev_reg;
   assign sample_pt = SUB_W'(phase_reg + adv_in);
   assign sample = sub_cnt_in == sample_pt;

   // phase aligner and sample history, both cleared by phase reset
   always_ff @(posedge clock_in or negedge phase_rst_n_in) begin
      if (!phase_rst_n_in) begin
         phase_reg <= CENTER_OFS;
         edge_cnt_reg <= '0;
         locked_out <= 1'h0;
         hist_reg <= '0;
         lane_bit_reg <= '0;
         word_out <= '0;
         rec_clock_out <= 1'h0;
      end else begin
         if (edge_seen && !hold_in) begin
            phase_reg <= SUB_W'(sub_cnt_in + CENTER_OFS);
            if (!locked_out) begin
               edge_cnt_reg <= EDGE_W'(edge_cnt_reg + 1'h1);
               if (edge_cnt_reg == EDGE_W'(LOCK_EDGES - 1)) begin
                  locked_out <= 1'h1;
               end
            end
         end
         if (sample) begin
            hist_reg <= {hist_reg[HIST_W-2:0], line_reg};
            lane_bit_reg <= (lane_bit_reg == BIT_W'(SER_FACTOR - 1)) ? '0 : BIT_W'(lane_bit_reg + 1'h1);
         end
         if (soft_cdr_in ? (sample && lane_bit_reg == '0) : word_tick_in) begin
            word_out <= hist_reg[slip_reg +: SER_FACTOR];
         end
         rec_clock_out <= soft_cdr_in && lane_bit_reg < BIT_W'(SER_FACTOR / 2);
      end
   end

   // bit-slip realignment and rollover pulse
   always_ff @(posedge clock_in or negedge realign_rst_n_in) begin
      if (!realign_rst_n_in) begin
         slip_reg <= '0;
         rollover_out <= 1'h0;
         roll_tmr_reg <= '0;
      end else begin
         if (align_in) begin
            if (slip_reg >= roll_cnt_in) begin
               slip_reg <= '0;
            end else begin
               slip_reg <= SLIP_W'(slip_reg + 1'h1);
            end
         end
         if (align_in && SLIP_W'(slip_reg + 1'h1) == roll_cnt_in) begin
            rollover_out <= 1'h1;
            roll_tmr_reg <= TMR_W'(WORD_M1);
         end else if (roll_tmr_reg != '0) begin
            roll_tmr_reg <= TMR_W'(roll_tmr_reg - 1'h1);
         end else begin
            rollover_out <= 1'h0;
         end
      end
   end

   property p_lock_sticky;
      @(posedge clock_in) disable iff (!phase_rst_n_in)
      locked_out |=> locked_out;
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("alignment lock fell");

   property p_roll_len;
      @(posedge clock_in) disable iff (!realign_rst_n_in)
      $rose(rollover_out) |-> ##WORD_M1 rollover_out ##1 !rollover_out;
   endproperty
   a_roll_len: assert property (p_roll_len) else $error("rollover not one word long");

   property p_roll_zero;
      @(posedge clock_in) disable iff (!realign_rst_n_in)
      align_in && rollover_out && slip_reg >= roll_cnt_in |=> slip_reg == '0;
   endproperty
   a_roll_zero: assert property (p_roll_zero) else $error("slip not returned to zero");

   property p_hold_phase;
      @(posedge clock_in) disable iff (!phase_rst_n_in)
      hold_in ##1 hold_in |-> $stable(phase_reg);
   endproperty
   a_hold_phase: assert property (p_hold_phase) else $error("phase moved while held");
endmodule

// ### logic/lvs_serdes_top.sv
/*
 serializer/deserializer pair with register slave, clock model,
 forwarded clock, calibration sequencer and per-channel lanes.
 assumes an avalon-mm master on the same clock; serial pins asynchronous.
*/
// The implementer's own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/100ps
// Overview of operation
// - phase reset clears aligner and its fifo
// - calibration busy high; phases advanced two steps
// - pll control outputs only with calibration mode
// - rollover pulses one word after programmed slips
// - align during rollover returns latency to zero
// - soft recovery mode gives per-lane divided clock
// - alignment lock rises once, falls only on phase reset
// - receive pll lock reflects lock state
// - parallel word per channel, concatenated, deser_factor wide
// - no receive parallel clock with external pll
// - transmit reset clears lanes, not pll
// - serialize msb first, bit zero last
// - forwarded clock full, half, quarter; 45 degree steps
// - transmit pll lock reflects lock state
// - pll reset clears all pll counters
// - realign reset clears bit-slip logic
// - hold low tracks phase, high keeps it
module lvs_serdes_top #(
   parameter int CHANNELS = 8,
   parameter int SER_FACTOR = 8,
   parameter int MAX_SLIP = 8,
   parameter bit CAL_ENABLE = 1'b1
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic pll_reset_in,
   input wire logic [CHANNELS-1:0] rx_phase_reset_in,
   input wire logic [CHANNELS-1:0] rx_realign_reset_in,
   input wire logic [CHANNELS-1:0] tx_data_reset_in,
   input wire logic [CHANNELS-1:0] rx_phase_hold_in,
   input wire logic [CHANNELS-1:0] rx_serial_in,
   input wire logic [CHANNELS*SER_FACTOR-1:0] tx_data_in,
   input wire logic [lvs_pkg::ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [lvs_pkg::DATA_W-1:0] avs_writedata_in,
   output logic [lvs_pkg::DATA_W-1:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic [CHANNELS*SER_FACTOR-1:0] rx_data_out,
   output logic rx_par_clock_out,
   output logic [CHANNELS-1:0] rx_rec_clock_out,
   output logic [CHANNELS-1:0] rx_rollover_out,
   output logic [CHANNELS-1:0] rx_dpa_locked_out,
   output logic rx_pll_locked_out,
   output logic cal_busy_out,
   output logic pll_counter_select_out,
   output logic pll_phase_step_out,
   output logic pll_phase_direction_out,
   output logic pll_scan_chain_clock_out,
   output logic tx_core_clock_out,
   output logic tx_fwd_clock_out,
   output logic [CHANNELS-1:0] tx_serial_out,
   output logic tx_pll_locked_out
);
   import lvs_pkg::*;
   localparam int BIT_W = $clog2(SER_FACTOR);
   localparam int SLIP_W = $clog2(MAX_SLIP + 1);
   localparam int LOCK_W = $clog2(PLL_LOCK_CYCLES + 1);
   localparam int CAL_W = $clog2(CAL_CYCLES + 1);
   localparam int LOCK_DLY = PLL_LOCK_CYCLES;
   localparam int CAL_M1 = CAL_CYCLES - 1;
   localparam int HALF_M1 = (SER_FACTOR / 2) * SUB_STEPS - 1;

   if (SER_FACTOR < 2 || SER_FACTOR > 16 || CHANNELS < 1 || CHANNELS > 8 || MAX_SLIP < 1 || MAX_SLIP > 15)
   begin : g_bad_params
      $error("lvs_serdes_top: unsupported channel count, factor or slip limit");
   end

   logic pll_rst_n;
   logic [LOCK_W-1:0] lock_cnt_reg;
   logic pll_locked;
   logic [FWD_W-1:0] fwd_cnt_reg;
   logic [BIT_W-1:0] bit_cnt_reg;
   logic [SUB_W-1:0] sub_cnt;
   logic bit_tick, word_tick;
   logic [FWD_W-1:0] fwd_pos, fwd_half;
   lvs_ctrl_type ctrl_reg, wr_ctrl;
   logic [SLIP_W-1:0] roll_cnt_reg;
   logic [CHANNELS-1:0] align_reg;
   logic av_req, wr_take;
   logic [DATA_W-1:0] rd_mux;
   lvs_cal_state_type cal_state_reg;
   logic [CAL_W-1:0] cal_cnt_reg;
   logic [SUB_W-1:0] sample_adv;

   // pll reset acts on the whole clock model asynchronously
   assign pll_rst_n = rst_n_in & ~pll_reset_in;

   // lock timer of the shared pll
   always_ff @(posedge clock_in or negedge pll_rst_n) begin
      if (!pll_rst_n) begin
         lock_cnt_reg <= '0;
      end else if (lock_cnt_reg != LOCK_W'(PLL_LOCK_CYCLES)) begin
         lock_cnt_reg <= LOCK_W'(lock_cnt_reg + 1'h1);
      end
   end

   assign pll_locked = lock_cnt_reg == LOCK_W'(PLL_LOCK_CYCLES);

   always_ff @(posedge clock_in or negedge pll_rst_n) begin
      if (!pll_rst_n) begin
         rx_pll_locked_out <= 1'h0;
         tx_pll_locked_out <= 1'h0;
      end else begin
         rx_pll_locked_out <= pll_locked;
         tx_pll_locked_out <= pll_locked;
      end
   end

   // fast, bit and word counters of the clock model
   always_ff @(posedge clock_in or negedge pll_rst_n) begin
      if (!pll_rst_n) begin
         fwd_cnt_reg <= '0;
         bit_cnt_reg <= '0;
      end else begin
         fwd_cnt_reg <= FWD_W'(fwd_cnt_reg + 1'h1);
         if (bit_tick) begin
            bit_cnt_reg <= (bit_cnt_reg == BIT_W'(SER_FACTOR - 1)) ? '0 : BIT_W'(bit_cnt_reg + 1'h1);
         end
      end
   end

   assign sub_cnt = fwd_cnt_reg[SUB_W-1:0];
   assign bit_tick = sub_cnt == SUB_LAST;
   assign word_tick = bit_tick && bit_cnt_reg == BIT_W'(SER_FACTOR - 1);

   // forwarded clock: period and phase scale with the divide code
   always_comb begin
      fwd_half = FWD_W'(SUB_STEPS / 2) << ctrl_reg.fwd_div;
      fwd_pos = FWD_W'(fwd_cnt_reg - (FWD_W'(ctrl_reg.fwd_phase) << ctrl_reg.fwd_div));
      fwd_pos = fwd_pos & FWD_W'((fwd_half << 1) - 1'h1);
   end

   // parallel-rate clocks to the fabric and the forwarded clock
   always_ff @(posedge clock_in or negedge pll_rst_n) begin
      if (!pll_rst_n) begin
         tx_core_clock_out <= 1'h0;
         rx_par_clock_out <= 1'h0;
         tx_fwd_clock_out <= 1'h0;
      end else begin
         tx_core_clock_out <= bit_cnt_reg < BIT_W'(SER_FACTOR / 2);
         rx_par_clock_out <= !ctrl_reg.ext_pll && bit_cnt_reg < BIT_W'(SER_FACTOR / 2);
         tx_fwd_clock_out <= fwd_pos < fwd_half;
      end
   end

   // register slave: waitrequest drops for one cycle per request
   assign av_req = avs_read_in | avs_write_in;
   assign wr_take = avs_write_in && !avs_waitrequest_out;
   assign wr_ctrl = lvs_ctrl_type'(avs_writedata_in[CTRL_W-1:0]);

   always_comb begin
      rd_mux = '0;
      if (avs_address_in == OFS_CTRL) begin
         rd_mux[CTRL_W-1:0] = ctrl_reg;
      end else if (avs_address_in == OFS_STATUS) begin
         rd_mux[ST_RX_LOCK] = rx_pll_locked_out;
         rd_mux[ST_TX_LOCK] = tx_pll_locked_out;
         rd_mux[ST_CAL_BUSY] = cal_busy_out;
         rd_mux[ST_DPA_LSB +: CHANNELS] = rx_dpa_locked_out;
         rd_mux[ST_ROLL_LSB +: CHANNELS] = rx_rollover_out;
      end else if (avs_address_in == OFS_ROLL) begin
         rd_mux[SLIP_W-1:0] = roll_cnt_reg;
      end
   end

   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         avs_waitrequest_out <= 1'h1;
         avs_readdata_out <= '0;
      end else if (av_req && avs_waitrequest_out) begin
         avs_waitrequest_out <= 1'h0;
         avs_readdata_out <= rd_mux;
      end else begin
         avs_waitrequest_out <= 1'h1;
      end
   end

   // software-written control state
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_reg <= CTRL_RESET;
         roll_cnt_reg <= SLIP_W'(MAX_SLIP);
         align_reg <= '0;
      end else begin
         align_reg <= '0;
         ctrl_reg.cal_start <= 1'h0;
         if (wr_take) begin
            if (avs_address_in == OFS_CTRL) begin
               ctrl_reg <= wr_ctrl;
               if (wr_ctrl.fwd_div == DIV_RSVD) begin
                  ctrl_reg.fwd_div <= DIV_QUARTER;
               end
            end else if (avs_address_in == OFS_SLIP) begin
               align_reg <= avs_writedata_in[CHANNELS-1:0];
            end else if (avs_address_in == OFS_ROLL) begin
               if (avs_writedata_in == '0 || avs_writedata_in > DATA_W'(MAX_SLIP)) begin
                  roll_cnt_reg <= SLIP_W'(MAX_SLIP);
               end else begin
                  roll_cnt_reg <= avs_writedata_in[SLIP_W-1:0];
               end
            end
         end
      end
   end

   // calibration sequencer, only reachable with calibration built in
   always_ff @(posedge clock_in or negedge pll_rst_n) begin
      if (!pll_rst_n) begin
         cal_state_reg <= CAL_IDLE;
         cal_cnt_reg <= '0;
      end else begin
         case (cal_state_reg)
            CAL_IDLE: begin
               if (CAL_ENABLE && ctrl_reg.cal_start && pll_locked) begin
                  cal_state_reg <= CAL_RUN;
                  cal_cnt_reg <= '0;
               end
            end
            CAL_RUN: begin
               if (cal_cnt_reg == CAL_W'(CAL_CYCLES - 1)) begin
                  cal_state_reg <= CAL_IDLE;
               end else begin
                  cal_cnt_reg <= CAL_W'(cal_cnt_reg + 1'h1);
               end
            end
            default: begin
               cal_state_reg <= CAL_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge pll_rst_n) begin
      if (!pll_rst_n) begin
         cal_busy_out <= 1'h0;
         pll_counter_select_out <= 1'h0;
         pll_phase_step_out <= 1'h0;
         pll_phase_direction_out <= 1'h0;
         pll_scan_chain_clock_out <= 1'h0;
      end else begin
         cal_busy_out <= cal_state_reg == CAL_RUN;
         pll_counter_select_out <= cal_state_reg == CAL_RUN;
         pll_phase_step_out <= cal_state_reg == CAL_RUN && cal_cnt_reg == '0;
         pll_phase_direction_out <= cal_state_reg == CAL_RUN;
         pll_scan_chain_clock_out <= cal_state_reg == CAL_RUN && !pll_scan_chain_clock_out;
      end
   end

   // sampling points run two steps ahead during calibration
   assign sample_adv = cal_busy_out ? CAL_ADVANCE : NO_ADVANCE;

   for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_lane
      logic rx_phase_rst_n, rx_realign_rst_n, tx_lane_rst_n;
      assign rx_phase_rst_n = rst_n_in & ~rx_phase_reset_in[ch];
      assign rx_realign_rst_n = rst_n_in & ~rx_realign_reset_in[ch];
      assign tx_lane_rst_n = rst_n_in & ~tx_data_reset_in[ch];

      lvs_rx_lane #(
         .SER_FACTOR(SER_FACTOR),
         .MAX_SLIP(MAX_SLIP),
         .SLIP_W(SLIP_W)
      ) u_rx (
         .clock_in(clock_in),
         .rst_n_in(rst_n_in),
         .phase_rst_n_in(rx_phase_rst_n),
         .realign_rst_n_in(rx_realign_rst_n),
         .serial_in(rx_serial_in[ch]),
         .hold_in(rx_phase_hold_in[ch]),
         .align_in(align_reg[ch]),
         .soft_cdr_in(ctrl_reg.soft_cdr),
         .word_tick_in(word_tick),
         .sub_cnt_in(sub_cnt),
         .adv_in(sample_adv),
         .roll_cnt_in(roll_cnt_reg),
         .word_out(rx_data_out[ch*SER_FACTOR +: SER_FACTOR]),
         .locked_out(rx_dpa_locked_out[ch]),
         .rollover_out(rx_rollover_out[ch]),
         .rec_clock_out(rx_rec_clock_out[ch])
      );

      lvs_tx_lane #(
         .SER_FACTOR(SER_FACTOR)
      ) u_tx (
         .clock_in(clock_in),
         .rst_n_in(tx_lane_rst_n),
         .load_in(word_tick),
         .shift_in(bit_tick),
         .word_in(tx_data_in[ch*SER_FACTOR +: SER_FACTOR]),
         .serial_out(tx_serial_out[ch])
      );
   end

   property p_wait_answer;
      @(posedge clock_in) disable iff (!rst_n_in)
      av_req && avs_waitrequest_out && !$past(av_req) |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
   endproperty
   a_wait_answer: assert property (p_wait_answer) else $error("waitrequest answer not one cycle");

   property p_lock_time;
      @(posedge clock_in) disable iff (!pll_rst_n)
      $rose(pll_rst_n) |-> ##LOCK_DLY !rx_pll_locked_out && !tx_pll_locked_out ##1 rx_pll_locked_out && tx_pll_locked_out;
   endproperty
   a_lock_time: assert property (p_lock_time) else $error("pll lock time wrong");

   property p_cal_len;
      @(posedge clock_in) disable iff (!pll_rst_n)
      $rose(cal_busy_out) |-> ##CAL_M1 cal_busy_out ##1 !cal_busy_out;
   endproperty
   a_cal_len: assert property (p_cal_len) else $error("calibration busy length wrong");

   property p_cal_pins;
      @(posedge clock_in) disable iff (!pll_rst_n)
      !cal_busy_out |-> !pll_scan_chain_clock_out && !pll_counter_select_out && !pll_phase_direction_out;
   endproperty
   a_cal_pins: assert property (p_cal_pins) else $error("pll control active outside calibration");

   property p_ext_pll;
      @(posedge clock_in) disable iff (!pll_rst_n)
      ctrl_reg.ext_pll |=> !rx_par_clock_out;
   endproperty
   a_ext_pll: assert property (p_ext_pll) else $error("parallel clock driven with external pll");

   property p_core_half;
      @(posedge clock_in) disable iff (!pll_rst_n)
      $rose(tx_core_clock_out) |-> ##HALF_M1 tx_core_clock_out ##1 !tx_core_clock_out;
   endproperty
   a_core_half: assert property (p_core_half) else $error("core clock high phase wrong");

   c_rollover: cover property (@(posedge clock_in) disable iff (!rst_n_in) |rx_rollover_out);
   c_cal_run: cover property (@(posedge clock_in) disable iff (!pll_rst_n) $rose(cal_busy_out));
   c_all_locked: cover property (@(posedge clock_in) disable iff (!rst_n_in) &rx_dpa_locked_out);
endmodule

// ### sim/lvs_remote_end.sv
/*
 remote link end: echoes each serial lane back one clock later.
 assumes the remote end shares the block clock.
*/
`timescale 1ns/100ps
module lvs_remote_end #(
   parameter int CH = 8
) (
   input wire logic clock_in,
   input wire logic [CH-1:0] line_in,
   output logic [CH-1:0] line_out
);
   initial line_out = '0;
   always @(posedge clock_in) begin
      line_out <= line_in;
   end
endmodule

// ### sim/lvs_serdes_tx_rx_ports_test.sv
/*
 bench for the serializer/deserializer top: registers, serial lanes, clocks.
 assumes the remote end loops transmit lanes back to the receiver.
*/
`timescale 1ns/100ps
module lvs_serdes_tx_rx_ports_test;
   import lvs_pkg::*;
   logic clock_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic pll_reset_in = 1'b0;
   logic [7:0] rx_phase_reset_in = 8'h00, rx_realign_reset_in = 8'h00, tx_data_reset_in = 8'h00;
   logic [7:0] rx_phase_hold_in = 8'h00, rx_serial_in, tx_serial_out, rx_rec_clock_out, rx_rollover_out;
   logic [7:0] rx_dpa_locked_out, s;
   logic [63:0] tx_data_in = 64'h8142A5C30F1E3CB4, rx_data_out;
   logic [3:0] avs_address_in = 4'h0;
   logic avs_read_in = 1'b0, avs_write_in = 1'b0, avs_waitrequest_out, rx_par_clock_out, cal_busy_out;
   logic rx_pll_locked_out, pll_counter_select_out, pll_phase_step_out, pll_phase_direction_out;
   logic pll_scan_chain_clock_out, tx_core_clock_out, tx_fwd_clock_out, tx_pll_locked_out;
   logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, q;
   logic [19:0] rows [7] = '{20'h00101, 20'h00302, 20'hC0008, 20'hC0908, 20'h15500, 20'h80000, 20'hC0303};
   int bad_count = 0, tests_run = 0, n;
   always #12.5 clock_in = ~clock_in;
   lvs_serdes_top uut (.clock_in, .rst_n_in, .pll_reset_in, .rx_phase_reset_in, .rx_realign_reset_in,
      .tx_data_reset_in, .rx_phase_hold_in, .rx_serial_in, .tx_data_in, .avs_address_in, .avs_read_in,
      .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .rx_data_out,
      .rx_par_clock_out, .rx_rec_clock_out, .rx_rollover_out, .rx_dpa_locked_out, .rx_pll_locked_out,
      .cal_busy_out, .pll_counter_select_out, .pll_phase_step_out, .pll_phase_direction_out,
      .pll_scan_chain_clock_out, .tx_core_clock_out, .tx_fwd_clock_out, .tx_serial_out, .tx_pll_locked_out);
   lvs_remote_end far (.clock_in, .line_in(tx_serial_out), .line_out(rx_serial_in));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      @(posedge clock_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      do begin @(posedge clock_in); end while (avs_waitrequest_out !== 1'b0);
      q = avs_readdata_out;
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
   endtask
   task automatic rise(ref logic sig);
      n = 0;
      while (sig !== 1'b0) begin @(posedge clock_in); n++; end
      while (sig !== 1'b1) begin @(posedge clock_in); n++; end
   endtask
   task automatic final_report;
      $display("checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clock_in);
      check({31'h0, avs_waitrequest_out}, 32'h1);
      rst_n_in <= 1'b1;
      repeat (100) @(posedge clock_in);
      check({30'h0, rx_pll_locked_out, tx_pll_locked_out}, 32'h3);
      foreach (rows[i]) begin
         bus(1'b1, rows[i][19:16], {24'h0, rows[i][15:8]});
         bus(1'b0, rows[i][19:16], 32'h0);
         check(q, {24'h0, rows[i][7:0]});
      end
      for (int k = 0; k < 3; k++) begin
         bus(1'b1, OFS_CTRL, 32'(k));
         repeat (3) rise(tx_fwd_clock_out);
         check(n, 8 << k);
      end
      rx_phase_hold_in <= 8'hFF;
      rise(tx_core_clock_out);
      repeat (4) @(posedge clock_in);
      repeat (8) begin s = {s[6:0], tx_serial_out[0]}; repeat (8) @(posedge clock_in); end
      check({24'h0, s}, 32'hB4);
      check({16'h0, rx_rec_clock_out, rx_dpa_locked_out}, 32'hFF);
      n = 0;
      s = tx_data_in[7:0];
      for (int r = 0; r < 8; r++) begin
         if (8'({s, s} >> r) == rx_data_out[7:0]) begin
            n = r;
         end
      end
      for (int c = 0; c < 8; c++) begin
         s = tx_data_in[c*8 +: 8];
         check({24'h0, rx_data_out[c*8 +: 8]}, {24'h0, 8'({s, s} >> n)});
      end
      rx_phase_hold_in <= 8'h00;
      s = tx_data_in[7:0];
      bus(1'b1, OFS_SLIP, 32'h1);
      bus(1'b1, OFS_SLIP, 32'h1);
      repeat (70) @(posedge clock_in);
      check({23'h0, rx_rollover_out[0], rx_data_out[7:0]}, {24'h0, 8'({s, s} >> ((n + 2) % 8))});
      bus(1'b1, OFS_SLIP, 32'h1);
      repeat (4) @(posedge clock_in);
      check({31'h0, rx_rollover_out[0]}, 32'h1);
      bus(1'b1, OFS_SLIP, 32'h1);
      repeat (70) @(posedge clock_in);
      check({24'h0, rx_data_out[7:0]}, {24'h0, 8'({s, s} >> n)});
      bus(1'b1, OFS_CTRL, 32'h80);
      repeat (3) @(posedge clock_in);
      check({27'h0, cal_busy_out, pll_counter_select_out, pll_phase_direction_out, pll_phase_step_out,
         pll_scan_chain_clock_out}, 32'h1F);
      repeat (40) @(posedge clock_in);
      check({27'h0, cal_busy_out, pll_counter_select_out, pll_phase_direction_out, pll_phase_step_out,
         pll_scan_chain_clock_out}, 32'h0);
      bus(1'b1, OFS_CTRL, 32'h60);
      @(posedge clock_in);
      s = 8'h00;
      repeat (80) begin @(posedge clock_in); s[0] = s[0] | rx_par_clock_out; s[1] = s[1] | rx_rec_clock_out[0]; end
      check({24'h0, s}, 32'h2);
      rx_phase_reset_in <= 8'hFF;
      rx_realign_reset_in <= 8'hFF;
      tx_data_reset_in <= 8'hFF;
      repeat (64) @(posedge clock_in);
      check({8'h0, rx_rollover_out, rx_dpa_locked_out, tx_serial_out}, 32'h0);
      rx_phase_reset_in <= 8'h00;
      rx_realign_reset_in <= 8'h00;
      tx_data_reset_in <= 8'h00;
      pll_reset_in <= 1'b1;
      @(posedge clock_in);
      pll_reset_in <= 1'b0;
      @(posedge clock_in);
      check({30'h0, rx_pll_locked_out, tx_pll_locked_out}, 32'h0);
      repeat (100) @(posedge clock_in);
      check({30'h0, rx_pll_locked_out, tx_pll_locked_out}, 32'h3);
      final_report;
   end
   initial begin
      repeat (20000) @(posedge clock_in);
      bad_count++;
      final_report;
   end
endmodule
